// *** verilog/serial_fmt_pkg.sv ***
/*
 * Shared constants, states and carrier structs of the serial framing block.
 * Assumes one 25 MHz clock and the plain register port of the top module.
 */
`default_nettype none
package serial_fmt_pkg;
    // ---------------------------------------------------------------
    // Register map
    // ---------------------------------------------------------------
    localparam logic [2:0] MODE_ADDR = 3'h0;
    localparam logic [2:0] CTRL_ADDR = 3'h1;
    localparam logic [2:0] DIV_ADDR = 3'h2;
    localparam logic [2:0] TXDATA_ADDR = 3'h3;
    localparam logic [2:0] RXDATA_ADDR = 3'h4;
    localparam logic [2:0] STATUS_ADDR = 3'h5;

    // ---------------------------------------------------------------
    // Mode, control and status fields
    // ---------------------------------------------------------------
    localparam int SYNC_SEL_BIT = 7;
    localparam int CHAR_LEN_BIT = 6;
    localparam int PARITY_EN_BIT = 5;
    localparam int PARITY_ODD_BIT = 4;
    localparam int STOP_LEN_BIT = 3;
    localparam int MULTIPROC_BIT = 2;
    localparam int TX_EN_BIT = 5;
    localparam int RX_EN_BIT = 4;
    localparam int MP_FLAG_BIT = 2;
    localparam int CLK_SEL_HI_BIT = 1;
    localparam int CLK_SEL_LO_BIT = 0;
    localparam int TX_EMPTY_BIT = 7;
    localparam int RX_FULL_BIT = 6;
    localparam int OVERRUN_BIT = 5;
    localparam int FRAME_ERR_BIT = 4;
    localparam int PARITY_ERR_BIT = 3;
    localparam int TX_END_BIT = 2;
    localparam int RX_MP_BIT = 1;

    // ---------------------------------------------------------------
    // Reset values and timing
    // ---------------------------------------------------------------
    localparam logic [7:0] MODE_RESET = 8'h00;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] DIV_RESET = 8'h0c;
    localparam logic [3:0] TICKS_PER_BIT_M1 = 4'hf;
    localparam logic [3:0] SAMPLE_TICK = 4'h7;
    localparam logic [3:0] OUT_CLK_RISE_TICK = 4'h8;
    localparam int DATA_BITS_MAX = 8;

    typedef enum logic [2:0] {
        IDLE, START, DATA, EXTRA, STOP1, STOP2
    } frame_state_e;

    // Settings shared by both shifters
    typedef struct packed {
        logic seven_bits;
        logic parity_en;
        logic parity_odd;
        logic two_stops;
        logic multiproc;
    } frame_fmt_s;

    // Result of one received character
    typedef struct packed {
        logic [7:0] data;
        logic mp_flag;
        logic parity_bad;
        logic stop_bad;
    } rx_result_s;
endpackage
`default_nettype wire

// *** verilog/serial_frame_rx.sv ***
/*
 * Receive shifter: finds the start edge, samples mid-bit on a 16x tick, one result
 * pulse per character. Assumes line_in is synchronous and tick_in one cycle wide.
 */
`default_nettype none
module serial_frame_rx (
    input wire logic clock_in,
    input wire logic rst_n_in,
    input wire logic enable_in,
    input wire logic tick_in,
    input wire logic line_in,
    input wire serial_fmt_pkg::frame_fmt_s fmt_in,
    output logic done_out,
    output serial_fmt_pkg::rx_result_s result_out
);
    serial_fmt_pkg::frame_state_e state, next_state;
    logic [3:0] tick_cnt, next_tick_cnt;
    logic [2:0] bit_cnt, next_bit_cnt;
    logic [7:0] shift, next_shift;
    logic ones, next_ones;
    logic line_d, next_line_d;
    logic done, next_done;
    serial_fmt_pkg::rx_result_s result, next_result;
    logic mid;

    // ---------------------------------------------------------------
    // Next state
    // ---------------------------------------------------------------
    always_comb begin
        next_state = state;
        next_tick_cnt = tick_cnt;
        next_bit_cnt = bit_cnt;
        next_shift = shift;
        next_ones = ones;
        next_line_d = line_in;
        next_done = 1'b0;
        next_result = result;
        mid = tick_in && (tick_cnt == serial_fmt_pkg::SAMPLE_TICK);
        if (tick_in) begin
            next_tick_cnt = tick_cnt + 4'h1;
        end
        case (state)
            serial_fmt_pkg::IDLE: begin
                // Falling edge restarts bit timing for every character
                if (enable_in && line_d && !line_in) begin
                    next_state = serial_fmt_pkg::START;
                    next_tick_cnt = 4'h0;
                end
            end
            serial_fmt_pkg::START: begin
                // False start if the line is back high at mid-bit
                if (mid) begin
                    next_state = line_in ? serial_fmt_pkg::IDLE : serial_fmt_pkg::DATA;
                    next_bit_cnt = 3'h0;
                    next_ones = 1'b0;
                end
            end
            serial_fmt_pkg::DATA: begin
                if (mid) begin
                    // LSB first: shift in from the top
                    next_shift = {line_in, shift[7:1]};
                    next_ones = ones ^ line_in;
                    next_bit_cnt = bit_cnt + 3'h1;
                    if (bit_cnt == (fmt_in.seven_bits ? 3'h6 : 3'h7)) begin
                        next_state = (fmt_in.multiproc || fmt_in.parity_en) ?
                            serial_fmt_pkg::EXTRA : serial_fmt_pkg::STOP1;
                    end
                end
            end
            serial_fmt_pkg::EXTRA: begin
                if (mid) begin
                    next_result.mp_flag = fmt_in.multiproc & line_in;
                    next_result.parity_bad = !fmt_in.multiproc &&
                        ((ones ^ line_in) != fmt_in.parity_odd);
                    next_state = serial_fmt_pkg::STOP1;
                end
            end
            serial_fmt_pkg::STOP1: begin
                // Only the first stop bit is checked
                if (mid) begin
                    next_result.data = fmt_in.seven_bits ? {1'b0, shift[7:1]} : shift;
                    next_result.stop_bad = !line_in;
                    if (!fmt_in.multiproc && !fmt_in.parity_en) begin
                        next_result.parity_bad = 1'b0;
                        next_result.mp_flag = 1'b0;
                    end
                    next_done = 1'b1;
                    next_state = serial_fmt_pkg::IDLE;
                end
            end
            default: next_state = serial_fmt_pkg::IDLE;
        endcase
        if (!enable_in) begin
            next_state = serial_fmt_pkg::IDLE;
        end
    end

    // ---------------------------------------------------------------
    // Registers
    // ---------------------------------------------------------------
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state <= serial_fmt_pkg::IDLE;
            tick_cnt <= 4'h0;
            bit_cnt <= 3'h0;
            shift <= 8'h00;
            ones <= 1'b0;
            line_d <= 1'b1;
            done <= 1'b0;
            result <= '0;
        end else begin
            state <= next_state;
            tick_cnt <= next_tick_cnt;
            bit_cnt <= next_bit_cnt;
            shift <= next_shift;
            ones <= next_ones;
            line_d <= next_line_d;
            done <= next_done;
            result <= next_result;
        end
    end

    assign done_out = done;
    assign result_out = result;
endmodule
`default_nettype wire

// *** verilog/async_serial_format_clock.sv ***
/*
 * Serial unit: frame formats, clock source, baud generator,
 * double-buffered shifters and register port.
 * Assumes pin inputs synchronous to clock_in; the clock pin is
 * split into in, out and enable outside.
 */
// Design decisions made here: the address map and the strobed register port.
`default_nettype none
// Notes on behaviour
// - Async, selects 00: internal clock, clock pin unused.
// - Async, select hi 0 lo 1: internal clock, bit-rate clock driven on pin.
// - Async, select hi 1: clock from pin at sixteen times the bit rate.
// - Sync select 1, hi 0: internal clock, drive clock out on the pin.
// - Sync select 1, hi 1: clock comes in on the serial clock pin.
// - Start and stop frame every character; resync per character.
// - Transmit and receive paths run independently, full duplex.
// - Holding registers ahead of the transmit shifter and behind the receive shifter allow back-to-back characters.
// - Line idles high; a fall to low starts a character.
// - Order: start low, data LSB first, parity or flag, stop high.
// - Receiver aligns bit timing to the start bit's falling edge.
// - Sixteen ticks per bit; receiver samples on the eighth tick.
// - Twelve formats; length bit 0 gives eight data bits, 1 gives seven.
// - Multiproc 0: parity enable adds parity; multiproc 1: flag bit instead.
// - Stop length 0 gives one stop bit, 1 gives two.
// - Driven async clock runs at bit rate, rising at each bit centre.
// - Parity follows the odd/even mode bit on send and check.
module async_serial_format_clock #(
    parameter logic [7:0] DIV_DEFAULT = serial_fmt_pkg::DIV_RESET
) (
    input wire logic clock_in,
    input wire logic rst_n_in,
    input wire logic [2:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [7:0] rdata_out,
    input wire logic rxd_in,
    output logic txd_out,
    input wire logic sck_in,
    output logic sck_out,
    output logic sck_oe_out
);
    logic [7:0] serial_mode_reg, next_serial_mode_reg;
    logic [7:0] serial_control_reg, next_serial_control_reg;
    logic [7:0] divisor, next_divisor;
    logic [7:0] tx_hold, next_tx_hold;
    logic tx_empty, next_tx_empty;
    logic [7:0] rx_hold, next_rx_hold;
    logic rx_full, next_rx_full, overrun, next_overrun;
    logic frame_err, next_frame_err, parity_err, next_parity_err;
    logic rx_mp, next_rx_mp, tx_end, next_tx_end;
    logic [7:0] rdata, next_rdata;
    logic [7:0] div_cnt, next_div_cnt;
    logic sck_d, next_sck_d;
    logic tick;
    serial_fmt_pkg::frame_fmt_s fmt;
    serial_fmt_pkg::rx_result_s rx_res;
    logic rx_done;
    serial_fmt_pkg::frame_state_e tx_state, next_tx_state;
    logic [3:0] tx_tick, next_tx_tick;
    logic [2:0] tx_bit, next_tx_bit;
    logic [7:0] tx_shift, next_tx_shift;
    logic tx_ones, next_tx_ones, tx_mp, next_tx_mp;
    logic txd, next_txd, sck_o, next_sck_o, sck_oe, next_sck_oe;
    logic tx_load;

    // Frame format from the mode register
    always_comb begin
        fmt.seven_bits = serial_mode_reg[serial_fmt_pkg::CHAR_LEN_BIT];
        fmt.parity_en = serial_mode_reg[serial_fmt_pkg::PARITY_EN_BIT];
        fmt.parity_odd = serial_mode_reg[serial_fmt_pkg::PARITY_ODD_BIT];
        fmt.two_stops = serial_mode_reg[serial_fmt_pkg::STOP_LEN_BIT];
        fmt.multiproc = serial_mode_reg[serial_fmt_pkg::MULTIPROC_BIT];
    end

    // ---------------------------------------------------------------
    // Clock source and 16x tick
    // ---------------------------------------------------------------
    // Pin clock is sampled as a level, one tick per rising edge;
    // it must stay at or below half of clock_in.
    always_comb begin
        next_div_cnt = div_cnt;
        next_sck_d = sck_in;
        tick = 1'b0;
        if (serial_control_reg[serial_fmt_pkg::CLK_SEL_HI_BIT]) begin
            tick = sck_in && !sck_d;
            next_div_cnt = 8'h00;
        end else if (div_cnt == divisor) begin
            tick = 1'b1;
            next_div_cnt = 8'h00;
        end else begin
            next_div_cnt = div_cnt + 8'h01;
        end
    end

    // ---------------------------------------------------------------
    // Register port
    // ---------------------------------------------------------------
    // A hardware set wins over a same-cycle software clear.
    always_comb begin
        next_serial_mode_reg = serial_mode_reg;
        next_serial_control_reg = serial_control_reg;
        next_divisor = divisor;
        next_tx_hold = tx_hold;
        next_tx_empty = tx_empty;
        next_rx_hold = rx_hold;
        next_rx_full = rx_full;
        next_overrun = overrun;
        next_frame_err = frame_err;
        next_parity_err = parity_err;
        next_rx_mp = rx_mp;
        next_tx_end = tx_end;
        next_rdata = 8'h00;
        if (rd_in) begin
            case (addr_in)
                serial_fmt_pkg::MODE_ADDR: next_rdata = serial_mode_reg;
                serial_fmt_pkg::CTRL_ADDR: next_rdata = serial_control_reg;
                serial_fmt_pkg::DIV_ADDR: next_rdata = divisor;
                serial_fmt_pkg::TXDATA_ADDR: next_rdata = tx_hold;
                serial_fmt_pkg::RXDATA_ADDR: next_rdata = rx_hold;
                serial_fmt_pkg::STATUS_ADDR: begin
                    next_rdata = {tx_empty, rx_full, overrun, frame_err, parity_err,
                                  tx_end, rx_mp, 1'b0};
                end
                default: next_rdata = 8'h00;
            endcase
        end
        if (wr_in) begin
            case (addr_in)
                serial_fmt_pkg::MODE_ADDR: next_serial_mode_reg = wdata_in;
                serial_fmt_pkg::CTRL_ADDR: next_serial_control_reg = wdata_in;
                serial_fmt_pkg::DIV_ADDR: next_divisor = wdata_in;
                serial_fmt_pkg::TXDATA_ADDR: begin
                    next_tx_hold = wdata_in;
                    next_tx_empty = 1'b0;
                    next_tx_end = 1'b0;
                end
                serial_fmt_pkg::STATUS_ADDR: begin
                    // Writing 0 clears a flag; writing 1 leaves it
                    next_rx_full = rx_full & wdata_in[serial_fmt_pkg::RX_FULL_BIT];
                    next_overrun = overrun & wdata_in[serial_fmt_pkg::OVERRUN_BIT];
                    next_frame_err = frame_err & wdata_in[serial_fmt_pkg::FRAME_ERR_BIT];
                    next_parity_err = parity_err & wdata_in[serial_fmt_pkg::PARITY_ERR_BIT];
                end
                default: ;
            endcase
        end
        if (tx_load) begin
            next_tx_empty = 1'b1;
        end
        // Disabling the transmitter empties the holding register
        if (!serial_control_reg[serial_fmt_pkg::TX_EN_BIT]) begin
            next_tx_empty = 1'b1;
        end
        if (tx_state == serial_fmt_pkg::STOP1 && tx_tick == 4'h0 && tick && tx_empty) begin
            next_tx_end = 1'b1;
        end
        // A result is dropped while the holding register is full or flagged
        if (rx_done) begin
            if (rx_full || overrun || frame_err || parity_err) begin
                next_overrun = next_overrun | rx_full;
            end else begin
                next_rx_hold = rx_res.data;
                next_rx_mp = rx_res.mp_flag;
                next_frame_err = rx_res.stop_bad;
                next_parity_err = rx_res.parity_bad;
                next_rx_full = !(rx_res.stop_bad || rx_res.parity_bad);
            end
        end
    end

    // ---------------------------------------------------------------
    // Transmitter and serial clock pin
    // ---------------------------------------------------------------
    always_comb begin
        next_tx_state = tx_state;
        next_tx_tick = tx_tick;
        next_tx_bit = tx_bit;
        next_tx_shift = tx_shift;
        next_tx_ones = tx_ones;
        next_tx_mp = tx_mp;
        tx_load = 1'b0;
        if (tick) begin
            next_tx_tick = tx_tick + 4'h1;
        end
        case (tx_state)
            serial_fmt_pkg::IDLE: begin
                if (!tx_empty && tick) begin
                    tx_load = 1'b1;
                    next_tx_shift = tx_hold;
                    next_tx_ones = 1'b0;
                    next_tx_mp = serial_control_reg[serial_fmt_pkg::MP_FLAG_BIT];
                    next_tx_tick = 4'h0;
                    next_tx_state = serial_fmt_pkg::START;
                end
            end
            serial_fmt_pkg::START: begin
                if (tick && tx_tick == serial_fmt_pkg::TICKS_PER_BIT_M1) begin
                    next_tx_bit = 3'h0;
                    next_tx_state = serial_fmt_pkg::DATA;
                end
            end
            serial_fmt_pkg::DATA: begin
                if (tick && tx_tick == serial_fmt_pkg::TICKS_PER_BIT_M1) begin
                    next_tx_ones = tx_ones ^ tx_shift[0];
                    next_tx_shift = {1'b0, tx_shift[7:1]};
                    next_tx_bit = tx_bit + 3'h1;
                    if (tx_bit == (fmt.seven_bits ? 3'h6 : 3'h7)) begin
                        next_tx_state = (fmt.multiproc || fmt.parity_en) ?
                            serial_fmt_pkg::EXTRA : serial_fmt_pkg::STOP1;
                    end
                end
            end
            serial_fmt_pkg::EXTRA: begin
                if (tick && tx_tick == serial_fmt_pkg::TICKS_PER_BIT_M1) begin
                    next_tx_state = serial_fmt_pkg::STOP1;
                end
            end
            serial_fmt_pkg::STOP1: begin
                if (tick && tx_tick == serial_fmt_pkg::TICKS_PER_BIT_M1) begin
                    next_tx_state = fmt.two_stops ? serial_fmt_pkg::STOP2 :
                        serial_fmt_pkg::IDLE;
                end
            end
            serial_fmt_pkg::STOP2: begin
                if (tick && tx_tick == serial_fmt_pkg::TICKS_PER_BIT_M1) begin
                    next_tx_state = serial_fmt_pkg::IDLE;
                end
            end
            default: next_tx_state = serial_fmt_pkg::IDLE;
        endcase
        if (!serial_control_reg[serial_fmt_pkg::TX_EN_BIT]) begin
            next_tx_state = serial_fmt_pkg::IDLE;
            tx_load = 1'b0;
        end
        // Line level for the bit now in flight; mark while idle
        case (next_tx_state)
            serial_fmt_pkg::START: next_txd = 1'b0;
            serial_fmt_pkg::DATA: next_txd = next_tx_shift[0];
            serial_fmt_pkg::EXTRA: begin
                next_txd = fmt.multiproc ? tx_mp : (next_tx_ones ^ fmt.parity_odd);
            end
            default: next_txd = 1'b1;
        endcase
        // Pin drive: out when internal source and (sync, or async with select lo)
        next_sck_oe = !serial_control_reg[serial_fmt_pkg::CLK_SEL_HI_BIT] &&
            (serial_mode_reg[serial_fmt_pkg::SYNC_SEL_BIT] ||
             serial_control_reg[serial_fmt_pkg::CLK_SEL_LO_BIT]);
        // Bit-rate clock rising mid-bit; the bit phase free-runs while idle
        next_sck_o = next_sck_oe && (next_tx_tick >= serial_fmt_pkg::OUT_CLK_RISE_TICK);
    end

    // Receive path shares the tick and the frame format
    serial_frame_rx rx_path (
        .clock_in(clock_in),
        .rst_n_in(rst_n_in),
        .enable_in(serial_control_reg[serial_fmt_pkg::RX_EN_BIT]),
        .tick_in(tick),
        .line_in(rxd_in),
        .fmt_in(fmt),
        .done_out(rx_done),
        .result_out(rx_res)
    );

    // ---------------------------------------------------------------
    // Registers
    // ---------------------------------------------------------------
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            serial_mode_reg <= serial_fmt_pkg::MODE_RESET;
            serial_control_reg <= serial_fmt_pkg::CTRL_RESET;
            divisor <= DIV_DEFAULT;
            tx_hold <= 8'h00;
            tx_empty <= 1'b1;
            rx_hold <= 8'h00;
            rx_full <= 1'b0;
            overrun <= 1'b0;
            frame_err <= 1'b0;
            parity_err <= 1'b0;
            rx_mp <= 1'b0;
            tx_end <= 1'b1;
            rdata <= 8'h00;
            div_cnt <= 8'h00;
            sck_d <= 1'b0;
            tx_state <= serial_fmt_pkg::IDLE;
            tx_tick <= 4'h0;
            tx_bit <= 3'h0;
            tx_shift <= 8'h00;
            tx_ones <= 1'b0;
            tx_mp <= 1'b0;
            txd <= 1'b1;
            sck_o <= 1'b0;
            sck_oe <= 1'b0;
        end else begin
            serial_mode_reg <= next_serial_mode_reg;
            serial_control_reg <= next_serial_control_reg;
            divisor <= next_divisor;
            tx_hold <= next_tx_hold;
            tx_empty <= next_tx_empty;
            rx_hold <= next_rx_hold;
            rx_full <= next_rx_full;
            overrun <= next_overrun;
            frame_err <= next_frame_err;
            parity_err <= next_parity_err;
            rx_mp <= next_rx_mp;
            tx_end <= next_tx_end;
            rdata <= next_rdata;
            div_cnt <= next_div_cnt;
            sck_d <= next_sck_d;
            tx_state <= next_tx_state;
            tx_tick <= next_tx_tick;
            tx_bit <= next_tx_bit;
            tx_shift <= next_tx_shift;
            tx_ones <= next_tx_ones;
            tx_mp <= next_tx_mp;
            txd <= next_txd;
            sck_o <= next_sck_o;
            sck_oe <= next_sck_oe;
        end
    end

    assign rdata_out = rdata;
    assign txd_out = txd;
    assign sck_out = sck_o;
    assign sck_oe_out = sck_oe;
endmodule
`default_nettype wire

// *** testbench/serial_unit_asserts.sv ***
/* Port checker for the serial unit.
   Assumes the divisor stays 0, so one tick per clock. */
`default_nettype none
module serial_unit_asserts (
    input wire logic clock_in,
    input wire logic rst_n_in,
    input wire logic [2:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic [7:0] rdata_out,
    input wire logic txd_out,
    input wire logic sck_out,
    input wire logic sck_oe_out
);
    logic [2:0] sel, sel_d, sel_dd; // Sync select, clock select hi, lo
    wire logic steady = sel == sel_d && sel == sel_dd;
    // Clock field shadow; copies wait out the pin register
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            {sel_dd, sel_d, sel} <= 9'h000;
        end else begin
            {sel_dd, sel_d} <= {sel_d, sel};
            if (wr_in && addr_in == 3'h0) sel[2] <= wdata_in[7];
            if (wr_in && addr_in == 3'h1) sel[1:0] <= wdata_in[1:0];
        end
    end
    default clocking @(posedge clock_in); endclocking
    default disable iff (!rst_n_in);
    quiet_read_a: assert property (!rd_in |=> rdata_out == 8'h00) else $error("stray data");
    low_bit_len_a: assert property ($fell(txd_out) |-> !txd_out [*8] ##1 !txd_out [*8])
        else $error("short low bit");
    high_bit_len_a: assert property ($rose(txd_out) |-> txd_out [*8] ##1 txd_out [*8])
        else $error("short high bit");
    pin_unused_a: assert property (steady && sel == 3'b000 |-> !sck_oe_out)
        else $error("pin driven");
    pin_bitclk_a: assert property (steady && sel == 3'b001 |-> sck_oe_out)
        else $error("pin idle");
    pin_input_a: assert property (steady && sel[1] |-> !sck_oe_out)
        else $error("pin driven");
    sync_drive_a: assert property (steady && sel[2:1] == 2'b10 |-> sck_oe_out)
        else $error("pin idle");
    clk_centre_a: assert property (steady && sel == 3'b001 && $fell(txd_out)
        |-> ##3 !sck_out ##[3:6] $rose(sck_out)) else $error("clock edge off centre");
    frame_c: cover property ($fell(txd_out));
    clk_out_c: cover property (steady && sel == 3'b001 && $rose(sck_out));
    ext_pin_c: cover property (steady && sel[1]);
endmodule
`default_nettype wire

// *** testbench/serial_remote.sv ***
/* Remote transceiver on the unit's lines.
   Assumes fmt_in matches the unit's mode; one tick per clock unless ext_in. */
`default_nettype none
module serial_remote (
    input wire logic clock_in,
    input wire logic ext_in,
    input wire serial_fmt_pkg::frame_fmt_s fmt_in,
    input wire logic line_in,
    output logic line_out,
    output logic sck_out
);
    logic [8:0] r;
    wire logic tk = !ext_in || sck_out; // Pin clock high, about to fall; the unit ticks on this edge
    initial begin
        sck_out = 1'b0;
        line_out = 1'b1;
    end
    // Free 16x clock; stopping it would upset the unit
    always @(posedge clock_in) sck_out <= ext_in ? !sck_out : 1'b0;
    // Trailing ones double as stops and idle
    task automatic send(input logic [7:0] d);
        logic [11:0] b;
        b = {3'b111, d, 1'b0};
        if (fmt_in.seven_bits) b[8] = 1'b1;
        if (fmt_in.parity_en || fmt_in.multiproc) b[fmt_in.seven_bits ? 8 : 9] =
            !fmt_in.multiproc && (^(d & {!fmt_in.seven_bits, 7'h7f}) ^ fmt_in.parity_odd);
        for (int i = 0; i < 12; i++) begin
            line_out <= b[i];
            repeat (16) @(posedge clock_in iff tk);
        end
    endtask
    // Sample each bit centre after a start edge
    always @(negedge line_in) begin
        repeat (8) @(posedge clock_in iff tk);
        for (int i = 0; i < 9; i++) begin
            repeat (16) @(posedge clock_in iff tk);
            r[i] = line_in;
        end
    end
endmodule
`default_nettype wire

// *** testbench/async_serial_format_clock_tb.sv ***
/* Bench: twelve formats both ways, clock pin modes, reset values.
   Assumes divisor 0 and the remote model on the pins. */
`default_nettype none
module async_serial_format_clock_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clock_in = 0, rst_n_in = 0, wr_in = 0, rd_in = 0, ext = 0, x, rxd, sck;
    logic [2:0] addr_in = 0;
    logic [7:0] wdata_in = 0, rdata_out, f = 0, d, v, m;
    logic txd_out, sck_out, sck_oe_out;
    int miscompares = 0, tests_run = 0, cyc = 0;
    logic [7:0] modes [12] = '{8'h00, 8'h08, 8'h30, 8'h28, 8'h40, 8'h48,
        8'h60, 8'h78, 8'h04, 8'h0c, 8'h44, 8'h4c};
    logic [3:0] pins [7] = '{4'b1001, 4'b0010, 4'b0011, 4'b1100, 4'b1101, 4'b0110, 4'b0000};
    wire logic pin = sck_oe_out ? sck_out : sck; // Shared clock pin
    async_serial_format_clock #(.DIV_DEFAULT(8'h00)) uut (.clock_in, .rst_n_in, .addr_in,
        .wdata_in, .wr_in, .rd_in, .rdata_out, .rxd_in(rxd), .txd_out, .sck_in(pin),
        .sck_out, .sck_oe_out);
    serial_remote remote (.clock_in, .ext_in(ext), .fmt_in(serial_fmt_pkg::frame_fmt_s'(f[6:2])),
        .line_in(txd_out), .line_out(rxd), .sck_out(sck));
    initial forever #20 clock_in = !clock_in;
    task automatic chk(input logic [7:0] seen, exp, input string what);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s exp %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] dv);
        @(posedge clock_in);
        wr_in <= 1'b1;
        addr_in <= a;
        wdata_in <= dv;
        @(posedge clock_in);
        wr_in <= 1'b0;
    endtask
    // Read data stands one cycle; sample mid-cycle
    task automatic rd(input logic [2:0] a);
        @(posedge clock_in);
        rd_in <= 1'b1;
        addr_in <= a;
        @(posedge clock_in);
        rd_in <= 1'b0;
        @(negedge clock_in);
        v = rdata_out;
    endtask
    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // Ceiling well above twelve duplex frames
    always @(posedge clock_in) begin
        cyc++;
        if (cyc == 30000) begin
            miscompares++;
            stop_test();
        end
    end
    initial begin
        repeat (8) @(posedge clock_in);
        rst_n_in <= 1'b1;
        rd(3'h0);
        chk(v, 8'h00, "mode reset");
        chk({7'h00, txd_out}, 8'h01, "idle line");
        for (int i = 0; i < 12; i++) begin
            f = modes[i];
            d = 8'h96 ^ 8'(i);
            m = f[6] ? 8'h7f : 8'hff;
            x = f[2] ? 1'b0 : f[5] ? ^(d & m) ^ f[4] : 1'b1;
            wr(3'h0, f);
            wr(3'h1, 8'h31);
            wr(3'h3, d);
            remote.send(~d); // Both directions at once
            repeat (20) @(posedge clock_in);
            chk(remote.r[7:0] & m, d & m, "sent data");
            chk({7'h00, remote.r[f[6] ? 7 : 8]}, {7'h00, x}, "extra bit");
            rd(3'h4);
            chk(v & m, ~d & m, "received data");
            wr(3'h5, 8'h00);
            wr(3'h1, 8'h00);
        end
        foreach (pins[j]) begin
            wr(3'h0, {pins[j][2], 7'h00});
            wr(3'h1, {6'h00, pins[j][1:0]});
            repeat (4) @(posedge clock_in);
            chk({7'h00, sck_oe_out}, {7'h00, pins[j][3]}, "pin enable");
        end
        f = 8'h00;
        ext = 1'b1;
        wr(3'h0, f);
        wr(3'h1, 8'h32);
        wr(3'h3, 8'h3c);
        repeat (450) @(posedge clock_in);
        chk(remote.r[7:0], 8'h3c, "external clock data");
        rd(3'h7);
        chk(v, 8'h00, "unmapped read");
        stop_test();
    end
endmodule
bind async_serial_format_clock serial_unit_asserts chk_u (.clock_in, .rst_n_in, .addr_in,
    .wdata_in, .wr_in, .rd_in, .rdata_out, .txd_out, .sck_out, .sck_oe_out);
`default_nettype wire
